/* design/asc_pkg.sv */
// constants and carriers for the serial command / configuration block
// assumes a 12-bit converter core next to it on the same clock
package asc_pkg;
  localparam int RES_W = 12;
  localparam int OUT_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 5;

  // command nibble codes
  localparam logic [3:0] CMD_CH_LAST = 4'hA;
  localparam logic [3:0] CMD_TEST_MID = 4'hB;
  localparam logic [3:0] CMD_TEST_NEG = 4'hC;
  localparam logic [3:0] CMD_TEST_POS = 4'hD;
  localparam logic [3:0] CMD_PWRDN = 4'hE;
  localparam logic [3:0] CMD_CFG2 = 4'hF;
  localparam logic [3:0] MUX_ZERO = 4'h0;

  // output length codes, bit 2 low means 12 bits
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [CNT_W-1:0] BITS_8 = 5'h08;
  localparam logic [CNT_W-1:0] BITS_12 = 5'h0C;
  localparam logic [CNT_W-1:0] BITS_16 = 5'h10;

  // reference source codes
  localparam logic [1:0] REF_INT_4V096 = 2'h0;
  localparam logic [1:0] REF_INT_2V048 = 2'h1;
  localparam logic [1:0] REF_EXT = 2'h3;

  // edge numbers within a transfer cycle
  localparam logic [CNT_W-1:0] FALL_SAMPLE = 5'h04;
  localparam logic [CNT_W-1:0] RISE_LEN = 5'h06;
  localparam logic [CNT_W-1:0] RISE_CMD = 5'h08;

  // reset and default-mode values
  localparam logic [3:0] CFG1_RST = 4'h0;
  localparam logic [3:0] CFG2_RST = 4'h0;
  localparam logic [3:0] CFG1_DEF = 4'h0;
  localparam logic STYLE_DEF = 1'b0;

  typedef struct packed {
    logic [1:0] len;
    logic lsb_first;
    logic bipolar;
  } asc_cfg1_s;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic int_style;
    logic default_mode;
  } asc_cfg2_s;
endpackage

/* design/asc_result_fmt.sv */
// builds the 16-bit shift word from a held 12-bit result
// assumes the caller always shifts out bit 15 first
`timescale 1ns/1ps
module asc_result_fmt
  import asc_pkg::*;
(
  input wire logic [asc_pkg::RES_W-1:0] result_i,
  input wire logic [1:0] len_i,
  input wire logic lsb_first_i,
  output logic [asc_pkg::OUT_W-1:0] word_o
);
  logic [OUT_W-1:0] msb_w;
  logic [OUT_W-1:0] rev_w;
  logic [OUT_W-1:0] lsb_w;

  // msb-first word: 16 pads four zeros, 8 keeps only the top bits
  assign msb_w = (len_i == LEN_8) ? {result_i[RES_W-1:4], 8'h00} :
                 {result_i, 4'h0};

  genvar i;
  generate
    for (i = 0; i < OUT_W; i++) begin : g_rev
      assign rev_w[i] = msb_w[OUT_W-1-i];
    end
  endgenerate

  // reversal of only the bits actually sent in each length
  assign lsb_w = (len_i == LEN_16) ? rev_w :
                 (len_i == LEN_8) ? {rev_w[7:0], 8'h00} :
                 {rev_w[11:0], 4'h0};

  assign word_o = lsb_first_i ? lsb_w : msb_w;
endmodule

/* design/asc_serial_ctrl.sv */
// serial command decoder, configuration registers and result shifter
// assumes pins arrive asynchronously; converter core shares clk_i
//
// Function
// - data-in high eight clocks enters default mode
// - command byte msb first on rising edges
// - nibble 0 to 10 selects input channel
// - nibbles 11-13 select midpoint, negative, positive tests
// - nibble 14 enters software power-down
// - low nibble goes to second or first register
// - command governs conversion after this cycle
// - length bits give 8, 12 or 16
// - 12-bit cycle ends on twelfth falling edge
// - 16-bit cycle pads zeros, ends sixteenth fall
// - 8-bit cycle drops low bits, ends eighth
// - length change takes effect at sixth rise
// - shift order change applies next cycle
// - unipolar result is plain unsigned code
// - bipolar result inverts the top bit
// - format change applies to following conversion
// - second register selects reference source
// - second register selects done or interrupt style
// - default bit forces configuration defaults
// - only first eight rising edges capture input
// - later result bits change on falling edges
// - interrupt low at latch, next rise clears
// - power-up clears registers, completion pin high
`timescale 1ns/1ps
module asc_serial_ctrl
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic io_clk_i,
  input wire logic serial_command_bits_i,
  input wire logic conv_done_i,
  input wire logic [asc_pkg::RES_W-1:0] conv_result_i,
  output logic data_out_o,
  output logic data_out_oe_o,
  output logic status_pin_o,
  output logic conv_start_o,
  output logic [3:0] channel_sel_o,
  output logic power_down_o,
  output logic [1:0] ref_sel_o,
  output logic default_mode_o
);
  import asc_pkg::*;

  // synchronised pins
  logic [2:0] sync_w;
  logic cs_n_s;
  logic io_clk_s;
  logic sdi_s;

  // chip select idles high: resetting its stages low would fake a select after reset
  asc_sync #(
    .W(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({cs_n_i, io_clk_i, serial_command_bits_i}),
    .q_o(sync_w)
  );

  assign cs_n_s = sync_w[2];
  assign io_clk_s = sync_w[1];
  assign sdi_s = sync_w[0];

  // state
  logic io_clk_d_r;
  logic cs_n_d_r;
  logic [CNT_W-1:0] rise_cnt_r;
  logic [CNT_W-1:0] fall_cnt_r;
  logic [BYTE_W-1:0] in_shift_r;
  asc_cfg1_s cfg1_r;
  asc_cfg2_s cfg2_r;
  logic [1:0] cyc_len_r;
  logic cyc_lsb_r;
  logic conv_bipolar_r;
  logic pend_pd_r;
  logic [RES_W-1:0] result_r;
  logic [OUT_W-1:0] out_word_r;
  logic data_out_r;
  logic oe_r;
  logic status_r;
  logic conv_start_r;
  logic [3:0] channel_r;
  logic power_down_r;
  logic [1:0] ref_r;
  logic def_r;

  // edge detection on the synchronised levels
  logic rise_w;
  logic fall_w;
  logic cs_fall_w;
  logic active_w;

  assign rise_w = io_clk_s & ~io_clk_d_r;
  assign fall_w = ~io_clk_s & io_clk_d_r;
  assign cs_fall_w = ~cs_n_s & cs_n_d_r;
  assign active_w = ~cs_n_s;

  // effective configuration after default-mode forcing
  logic def_mode_w;
  asc_cfg1_s cfg1_eff_w;
  logic int_style_w;
  logic [1:0] ref_eff_w;

  assign def_mode_w = cfg2_r.default_mode;
  assign cfg1_eff_w = def_mode_w ? asc_cfg1_s'(CFG1_DEF) : cfg1_r;
  assign int_style_w = def_mode_w ? STYLE_DEF : cfg2_r.int_style;
  assign ref_eff_w = def_mode_w ? REF_EXT : cfg2_r.ref_sel;

  // rising-edge capture; the bit being taken is sdi_s
  logic [CNT_W-1:0] rise_num_w;
  logic [CNT_W-1:0] fall_num_w;
  logic capture_w;
  logic [BYTE_W-1:0] byte_w;
  logic [3:0] cmd_nib_w;
  logic [3:0] cfg_nib_w;
  logic [5:0] six_w;

  assign rise_num_w = rise_cnt_r + 5'h01;
  assign fall_num_w = fall_cnt_r + 5'h01;
  assign capture_w = active_w & rise_w & (rise_cnt_r < RISE_CMD);
  assign byte_w = {in_shift_r[6:0], sdi_s};
  assign cmd_nib_w = byte_w[7:4];
  assign cfg_nib_w = byte_w[3:0];
  assign six_w = {in_shift_r[4:0], sdi_s};

  // length decision at the sixth rise, taken from the byte in flight
  logic len_event_w;
  logic len_write_w;

  assign len_event_w = capture_w & (rise_num_w == RISE_LEN);
  assign len_write_w = len_event_w & (six_w[5:2] != CMD_CFG2) & ~def_mode_w;

  // full byte decode at the eighth rise
  logic cmd_event_w;
  logic cfg2_access_w;
  logic def_next_w;

  assign cmd_event_w = capture_w & (rise_num_w == RISE_CMD);
  assign cfg2_access_w = cmd_nib_w == CMD_CFG2;
  assign def_next_w = cfg2_access_w ? cfg_nib_w[0] : def_mode_w;

  // command nibble seen once four bits are in
  logic sample_event_w;
  logic [3:0] early_nib_w;
  logic early_channel_w;

  assign sample_event_w = active_w & fall_w & (fall_num_w == FALL_SAMPLE);
  assign early_nib_w = in_shift_r[3:0];
  // channels 0-10 and the three test voltages all go to the mux
  assign early_channel_w = early_nib_w <= CMD_TEST_POS;

  // end of transfer cycle at the selected length
  logic [CNT_W-1:0] cyc_bits_w;
  logic cyc_end_w;

  assign cyc_bits_w = (cyc_len_r == LEN_8) ? BITS_8 :
                      (cyc_len_r == LEN_16) ? BITS_16 : BITS_12;
  assign cyc_end_w = active_w & fall_w & (fall_num_w == cyc_bits_w);

  // shift word for a freshly loaded result
  logic [OUT_W-1:0] fmt_word_w;
  logic [RES_W-1:0] coded_w;

  asc_result_fmt u_fmt (
    .result_i(result_r),
    .len_i(cyc_len_r),
    .lsb_first_i(cyc_lsb_r),
    .word_o(fmt_word_w)
  );

  // two's complement differs from unsigned only in the top bit
  assign coded_w = {conv_result_i[RES_W-1] ^ conv_bipolar_r,
                    conv_result_i[RES_W-2:0]};

  // edge history
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      io_clk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      io_clk_d_r <= io_clk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // edge counters; chip select high aborts the cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else if (!active_w || cyc_end_w) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else begin
      if (rise_w && rise_cnt_r < BITS_16) begin
        rise_cnt_r <= rise_num_w;
      end
      if (fall_w) begin
        fall_cnt_r <= fall_num_w;
      end
    end
  end

  // input byte shifter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_shift_r <= '0;
    end else if (capture_w) begin
      in_shift_r <= byte_w;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg1_r <= asc_cfg1_s'(CFG1_RST);
      cfg2_r <= asc_cfg2_s'(CFG2_RST);
    end else if (cmd_event_w) begin
      if (cfg2_access_w) begin
        cfg2_r <= asc_cfg2_s'(cfg_nib_w);
      end else begin
        cfg1_r <= asc_cfg1_s'(cfg_nib_w);
      end
    end
  end

  // per-cycle length and order; order only moves at a cycle boundary
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_len_r <= CFG1_RST[3:2];
      cyc_lsb_r <= 1'b0;
    end else if (len_write_w) begin
      cyc_len_r <= six_w[1:0];
    end else if (cyc_end_w) begin
      cyc_len_r <= cfg1_eff_w.len;
      cyc_lsb_r <= cfg1_eff_w.lsb_first;
    end
  end

  // pending command for the conversion after this cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_pd_r <= 1'b1;
    end else if (cmd_event_w) begin
      pend_pd_r <= cmd_nib_w == CMD_PWRDN;
    end
  end

  // channel mux select; default mode pins input zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      channel_r <= MUX_ZERO;
    end else if (cmd_event_w && def_next_w) begin
      channel_r <= MUX_ZERO;
    end else if (sample_event_w && early_channel_w && !def_mode_w) begin
      channel_r <= early_nib_w;
    end
  end

  // software power-down: starts at fourth fall, ends on a real conversion
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_down_r <= 1'b1;
    end else if (sample_event_w && early_nib_w == CMD_PWRDN) begin
      power_down_r <= 1'b1;
    end else if (cyc_end_w && !pend_pd_r) begin
      power_down_r <= 1'b0;
    end
  end

  // conversion start pulse and latched output format
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_start_r <= 1'b0;
      conv_bipolar_r <= 1'b0;
    end else begin
      conv_start_r <= cyc_end_w & ~pend_pd_r;
      if (cyc_end_w) begin
        conv_bipolar_r <= cfg1_eff_w.bipolar;
      end
    end
  end

  // held result; survives power-down and chip select
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_r <= '0;
    end else if (conv_done_i) begin
      result_r <= coded_w;
    end
  end

  // output shifter; forced low while a conversion runs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_word_r <= '0;
    end else if (cyc_end_w) begin
      out_word_r <= '0;
    end else if (cs_fall_w) begin
      out_word_r <= fmt_word_w;
    end else if (active_w && conv_done_i) begin
      out_word_r <= {coded_w, 4'h0};
    end else if (active_w && fall_w) begin
      out_word_r <= {out_word_r[OUT_W-2:0], 1'b0};
    end
  end

  // pin copy of bit 15, except an lsb-first direct load, which takes coded bit 0; on a direct load the coded value is used
  // because result_r is one clock behind conv_done_i
  logic load_bit_w;
  assign load_bit_w = cyc_lsb_r ? coded_w[0] : coded_w[RES_W-1];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= active_w;
      if (cyc_end_w) begin
        data_out_r <= 1'b0;
      end else if (cs_fall_w) begin
        data_out_r <= fmt_word_w[OUT_W-1];
      end else if (active_w && conv_done_i) begin
        data_out_r <= load_bit_w;
      end else if (active_w && fall_w) begin
        data_out_r <= out_word_r[OUT_W-2];
      end
    end
  end

  // completion pin: done style goes low for the conversion,
  // interrupt style pulses low at latch until the next selected rise or chip select fall
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= 1'b1;
    end else if (int_style_w) begin
      if (conv_done_i) begin
        status_r <= 1'b0;
      end else if ((active_w && rise_w) || cs_fall_w) begin
        status_r <= 1'b1;
      end
    end else begin
      if (conv_start_r) begin
        status_r <= 1'b0;
      end else if (conv_done_i) begin
        status_r <= 1'b1;
      end
    end
  end

  // registered copies of reference and mode for the analog side
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_r <= CFG2_RST[3:2];
      def_r <= 1'b0;
    end else begin
      ref_r <= ref_eff_w;
      def_r <= def_mode_w;
    end
  end

  // a fresh result is loaded whenever the link can see it;
  // a length change mid-cycle is not re-formatted, so an lsb-first
  // word may come out wrong once, which the host must tolerate

  assign data_out_o = data_out_r;
  assign data_out_oe_o = oe_r;
  assign status_pin_o = status_r;
  assign conv_start_o = conv_start_r;
  assign channel_sel_o = channel_r;
  assign power_down_o = power_down_r;
  assign ref_sel_o = ref_r;
  assign default_mode_o = def_r;
endmodule

/* design/asc_sync.sv */
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module asc_sync #(
  parameter int W = 3,
  // per-bit reset level; set it to each pin's idle level so no false edge follows reset
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

/* testbench/asc_host_model.sv */
// host serial port model: chip select, transfer clock and command bits
// assumes the bench resolves the released data-out line onto sdo_i
`timescale 1ns/1ps
module asc_host_model (
  input wire logic sdo_i,
  input wire logic hold_cs_i,
  output logic cs_n_o,
  output logic io_clk_o,
  output logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    io_clk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // transfer clock stands low outside frames; result bits read late in the high phase
  task automatic xfer(input logic [7:0] cmd, input int nclk, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_o = 1'b0;
    #300;
    for (int i = 0; i < nclk; i++) begin
      sdi_o = (i < 8) ? cmd[7 - i] : cmd[i % 8];
      #200 io_clk_o = 1'b1;
      #190 rx = {rx[14:0], sdo_i};
      #10 io_clk_o = 1'b0;
    end
    // with hold_cs_i set, chip select stays low across the conversion
    if (!hold_cs_i) begin
      #300 cs_n_o = 1'b1;
    end
  endtask
endmodule

/* testbench/asc_serial_ctrl_monitor.sv */
// port-level checker for the serial command and configuration block
// assumes it is bound to asc_serial_ctrl and sees only its ports
`timescale 1ns/1ps
module asc_serial_ctrl_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic io_clk_i,
  input wire logic conv_done_i,
  input wire logic data_out_o,
  input wire logic data_out_oe_o,
  input wire logic status_pin_o,
  input wire logic conv_start_o,
  input wire logic [3:0] channel_sel_o,
  input wire logic power_down_o
);
  import asc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  // the start follows the last falling transfer edge, never a high clock
  a_start_after_fall: assert property (conv_start_o |-> !io_clk_i && !$past(io_clk_i, 3))
    else $error("conversion start without a falling transfer edge");
  a_oe_tracks_cs: assert property ($stable(cs_n_i) [*4] |-> data_out_oe_o == !cs_n_i)
    else $error("output enable does not follow chip select");
  a_out_on_fall: assert property ($changed(data_out_o) && !cs_n_i && !$past(cs_n_i, 5)
    && !$past(conv_done_i) |-> $past(io_clk_i, 6) && !$past(io_clk_i, 2))
    else $error("serial output changed away from a falling edge");
  a_chan_in_range: assert property (channel_sel_o <= CMD_TEST_POS)
    else $error("channel code outside the selectable range");
  a_pd_fourth_fall: assert property ($rose(power_down_o) |->
    !io_clk_i && $past(io_clk_i, 5) && $stable(channel_sel_o))
    else $error("power-down entered away from the fourth falling edge");
  a_status_fall_cause: assert property ($fell(status_pin_o) |->
    conv_start_o || $past(conv_start_o) || $past(conv_done_i))
    else $error("completion pin fell without start or done");
  a_int_cleared: assert property (!cs_n_i && !status_pin_o && $rose(io_clk_i) |->
    ##[1:5] status_pin_o)
    else $error("interrupt flag not cleared by transfer clock rise");
  a_done_marks_pin: assert property (conv_done_i |=> $changed(status_pin_o))
    else $error("completion pin did not react to conversion done");

  c_conversion: cover property (conv_start_o);
  c_power_down: cover property ($rose(power_down_o));
  c_int_style: cover property ($fell(status_pin_o) && $past(conv_done_i));
  c_int_by_rise: cover property (!cs_n_i && !status_pin_o && $rose(io_clk_i));
endmodule

bind asc_serial_ctrl asc_serial_ctrl_monitor asc_serial_ctrl_monitor_i (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .cs_n_i(cs_n_i),
  .io_clk_i(io_clk_i),
  .conv_done_i(conv_done_i),
  .data_out_o(data_out_o),
  .data_out_oe_o(data_out_oe_o),
  .status_pin_o(status_pin_o),
  .conv_start_o(conv_start_o),
  .channel_sel_o(channel_sel_o),
  .power_down_o(power_down_o)
);

/* testbench/tb.sv */
// self-checking bench for the serial command and configuration block
// assumes a converter core answering ten cycles after each start
`timescale 1ns/1ps
module tb;
  import asc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [RES_W-1:0] conv_result_i = 12'h000;
  logic cs_n, io_clk, serial_command_bits, data_out, oe, status, conv_start, pwr_dn, dflt;
  logic sdo_q = 1'b0;
  logic hold_cs = 1'b0;
  wire sdo_w;
  logic [3:0] chan;
  logic [1:0] ref_sel;
  logic [11:0] res_val = 12'h000;
  logic [11:0] prev_r = 12'h000;
  logic [15:0] rx;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int start_cnt = 0;

  asc_serial_ctrl asc_serial_ctrl_i (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
    .io_clk_i(io_clk), .serial_command_bits_i(serial_command_bits), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .data_out_o(data_out), .data_out_oe_o(oe),
    .status_pin_o(status), .conv_start_o(conv_start), .channel_sel_o(chan),
    .power_down_o(pwr_dn), .ref_sel_o(ref_sel), .default_mode_o(dflt));
  asc_host_model asc_host_model_i (.sdo_i(sdo_w), .hold_cs_i(hold_cs), .cs_n_o(cs_n),
    .io_clk_o(io_clk), .sdi_o(serial_command_bits));

  // a released output line shows a changing pattern, never a stale bit
  assign sdo_w = oe ? data_out : ~sdo_q;
  always @(posedge clk_i) sdo_q <= sdo_w;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  always @(posedge clk_i) begin
    if (conv_start) begin
      start_cnt++;
      repeat (10) @(posedge clk_i);
      #1 conv_result_i = res_val;
      conv_done_i = 1'b1;
      @(posedge clk_i);
      #1 conv_done_i = 1'b0;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] fmt(input logic [11:0] r, input int n, input bit bip,
                                      input bit lsb);
    logic [15:0] w;
    logic [15:0] v;
    w = {r ^ {bip, 11'h000}, 4'h0} >> (16 - n);
    v = 16'h0000;
    for (int i = 0; i < n; i++) v[i] = w[n - 1 - i];
    return lsb ? v : w;
  endfunction

  // one frame; nxt is what the conversion after this frame will return
  task automatic cyc(input logic [7:0] cmd, input int n, input logic [11:0] nxt);
    prev_r = res_val;
    res_val = nxt;
    @(posedge clk_i);
    #1 asc_host_model_i.xfer(cmd, n, rx);
    for (int k = 0; k < 100 && !conv_done_i; k++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic sc_channels();
    int s;
    cyc(8'h00, 12, 12'h5A5);
    for (int c = 1; c <= 13; c++) begin
      cyc({c[3:0], 4'h0}, 12, {c[3:0], 8'hC3});
      check({12'h000, chan}, c[15:0]);
      check(rx, fmt(prev_r, 12, 0, 0));
    end
    s = start_cnt;
    cyc(8'hE0, 12, 12'h000);
    check({11'h000, pwr_dn, chan}, 16'h001D);
    check(16'(start_cnt - s), 16'h0000);
  endtask

  task automatic sc_format();
    cyc(8'h00, 12, 12'h3C5);
    cyc(8'h01, 12, 12'h000);
    check(rx, fmt(prev_r, 12, 0, 0));
    cyc(8'h0C, 16, 12'hFFF);
    check(rx, fmt(prev_r, 16, 1, 0));
    cyc(8'h04, 8, 12'h800);
    check(rx, fmt(prev_r, 8, 0, 0));
    cyc(8'h02, 12, 12'h9E1);
    check(rx, fmt(prev_r, 12, 0, 0));
    cyc(8'h00, 12, 12'h2B7);
    check(rx, fmt(prev_r, 12, 0, 1));
    cyc(8'h00, 12, 12'h6D2);
    check(rx, fmt(prev_r, 12, 0, 0));
  endtask

  task automatic sc_cfg2();
    logic [1:0] codes [3] = '{REF_INT_4V096, REF_INT_2V048, REF_EXT};
    for (int i = 0; i < 3; i++) begin
      cyc({4'hF, codes[i], 2'h0}, 12, 12'h6D2);
      check({14'h0000, ref_sel}, {14'h0000, codes[i]});
    end
    check(rx, fmt(prev_r, 12, 0, 0));
    cyc(8'hFE, 12, 12'h1F0);
    check({15'h0000, status}, 16'h0000);
    // cs left low: the result follows done, and the next rise clears the flag
    hold_cs = 1'b1;
    cyc(8'hFE, 12, 12'h2C3);
    check({15'h0000, status}, 16'h0000);
    check(rx, fmt(prev_r, 12, 0, 0));
    hold_cs = 1'b0;
    cyc(8'hFC, 12, 12'h0F1);
    check({15'h0000, status}, 16'h0001);
    check(rx, fmt(prev_r, 12, 0, 0));
  endtask

  task automatic sc_default();
    cyc(8'hFF, 12, 12'h444);
    check({11'h000, dflt, ref_sel, 2'h0}, 16'h001C);
    check({12'h000, chan}, 16'h0000);
    cyc(8'h31, 12, 12'hA5A);
    check({12'h000, chan}, 16'h0000);
    cyc(8'h00, 12, 12'h000);
    check(rx, fmt(prev_r, 12, 0, 0));
    cyc(8'hF0, 12, 12'h000);
    check({13'h0000, dflt, ref_sel}, 16'h0000);
    cyc(8'h21, 12, 12'h000);
    check({12'h000, chan}, 16'h0002);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (3) @(posedge clk_i);
    check({10'h000, status, pwr_dn, dflt, conv_start, ref_sel}, 16'h0030);
    check({12'h000, chan}, 16'h0000);
    sc_channels();
    sc_format();
    sc_cfg2();
    sc_default();
    end_of_test();
  end
endmodule
